// ### inc/risc_exec_pkg.sv
// constants, opcodes and states shared by the execute block
package risc_exec_pkg;
  localparam int DATA_W = 32;
  localparam int INSTR_W = 16;
  localparam int RIDX_W = 5;
  localparam int BUS_AW = 8;
  // ==================== instruction fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int SRC_MSB = 9;
  localparam int SRC_LSB = 5;
  localparam int DST_MSB = 4;
  localparam int DST_LSB = 0;
  // ==================== opcodes
  localparam logic [5:0] OP_ADD = 6'h00;
  localparam logic [5:0] OP_ADD_WITH_CARRY_IN = 6'h01;
  localparam logic [5:0] OP_ADD_QUICK = 6'h02;
  localparam logic [5:0] OP_ADD_QUICK_FLAGLESS = 6'h03;
  localparam logic [5:0] OP_AND = 6'h09;
  localparam logic [5:0] OP_BPROBE = 6'h0D;
  localparam logic [5:0] OP_BIT_SET_OP = 6'h0E;
  localparam logic [5:0] OP_BIT_CLEAR_OP = 6'h0F;
  localparam logic [5:0] OP_IMUL = 6'h11;
  localparam logic [5:0] OP_IMULN = 6'h12;
  localparam logic [5:0] OP_IMACN = 6'h14;
  localparam logic [5:0] OP_DIV = 6'h15;
  localparam logic [5:0] OP_MAG = 6'h16;
  localparam logic [5:0] OP_CMP = 6'h1E;
  localparam logic [5:0] OP_COMPARE_QUICK = 6'h1F;
  localparam logic [5:0] OP_LDB = 6'h27;
  localparam logic [5:0] OP_LDH = 6'h28;
  localparam logic [5:0] OP_LD = 6'h29;
  localparam logic [5:0] OP_LDQA = 6'h2B;
  localparam logic [5:0] OP_LDQB = 6'h2C;
  localparam logic [5:0] OP_JABS = 6'h34;
  localparam logic [5:0] OP_JREL = 6'h35;
  localparam logic [5:0] OP_LDRA = 6'h3A;
  localparam logic [5:0] OP_LDRB = 6'h3B;
  // ==================== special registers and values
  localparam logic [4:0] IDX_BASE_A = 5'h0E;
  localparam logic [4:0] IDX_BASE_B = 5'h0F;
  localparam logic [31:0] MIN_NEG = 32'h8000_0000;
  localparam logic [31:0] QUICK_ZERO_VAL = 32'h0000_0020;
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [4:0] DIV_ITER = 5'h10;
  // ==================== condition code bits
  localparam int CC_ZCLR = 0;
  localparam int CC_ZSET = 1;
  localparam int CC_FCLR = 2;
  localparam int CC_FSET = 3;
  localparam int CC_FSEL = 4;
  // ==================== memory sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // ==================== register map (byte offsets)
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_REMAIN = 8'h0C;
  localparam logic [7:0] OFS_ACC = 8'h10;
  localparam logic [7:0] OFS_REG_SEL = 8'h14;
  localparam logic [7:0] OFS_REG_DATA = 8'h18;
  localparam int STB_BUSY = 0;
  localparam int STB_ZERO = 1;
  localparam int STB_NEG = 2;
  localparam int STB_CARRY = 3;
  localparam int STB_JUMP = 4;
  // ==================== bus data phase steps
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_ONE = 2'h1;
  localparam logic [1:0] PH_TWO = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_EXEC, ST_WB, ST_DIV, ST_ADDR, ST_MEM
  } exec_state_t;
endpackage

// ### src/reg_bank_2r1w.sv
// register bank, two registered read ports and one write port
`timescale 1ns/1ns
`default_nettype none
module reg_bank_2r1w #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read ports
  input  wire logic [AW-1:0] raddr_a,
  input  wire logic [AW-1:0] raddr_b,
  output var  logic [DW-1:0] rdata_a_ff,
  output var  logic [DW-1:0] rdata_b_ff
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a_ff <= mem[raddr_a];
    rdata_b_ff <= mem[raddr_b];
  end
endmodule // reg_bank_2r1w
`default_nettype wire

// ### src/risc_alu_branch_load_exec.sv
// execute block: alu, divide, multiply, jumps and loads behind an ahb-lite slave
`timescale 1ns/1ns
`default_nettype none
module risc_alu_branch_load_exec (
  // clock and reset
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [risc_exec_pkg::BUS_AW-1:0] haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [risc_exec_pkg::DATA_W-1:0] hwdata,
  input  wire logic                             hready,
  output var  logic [risc_exec_pkg::DATA_W-1:0] hrdata_ff,
  output var  logic                             hreadyout_ff,
  output var  logic                             hresp_ff,
  // memory bus
  output var  logic                             mem_req_ff,
  output var  logic [risc_exec_pkg::DATA_W-1:0] mem_addr_ff,
  output var  logic [1:0]                       mem_size_ff,
  input  wire logic                             mem_ack,
  input  wire logic                             mem_internal,
  input  wire logic [risc_exec_pkg::DATA_W-1:0] mem_rdata
);
  import risc_exec_pkg::*;

  exec_state_t        st_ff, nxt_st;
  logic [15:0]        instr_ff;
  logic               z_ff, n_ff, c_ff, jump_ff;
  logic [31:0]        pc_ff, acc_ff, rem_ff, quo_ff, dsr_ff;
  logic [4:0]         cnt_ff, reg_sel_ff;
  logic               wb_en_ff;
  logic [31:0]        wb_data_ff;
  logic [1:0]         phase_ff;
  logic [7:0]         dp_addr_ff;
  logic               dp_write_ff;
  logic [31:0]        opa, opb;

  // ==================== decode
  // field split
  wire [5:0]  op    = instr_ff[OP_MSB:OP_LSB];
  wire [4:0]  src_f = instr_ff[SRC_MSB:SRC_LSB];
  wire [4:0]  dst_f = instr_ff[DST_MSB:DST_LSB];
  wire is_ldq  = (op == OP_LDQA) || (op == OP_LDQB);
  wire is_ldr  = (op == OP_LDRA) || (op == OP_LDRB);
  wire is_ldd  = (op == OP_LD) || (op == OP_LDB) || (op == OP_LDH);
  wire is_jmp  = (op == OP_JABS) || (op == OP_JREL);
  wire use_b   = (op == OP_LDQB) || (op == OP_LDRB);
  wire [4:0] base_r = use_b ? IDX_BASE_B : IDX_BASE_A;

  // ==================== bus decode
  wire accept   = hsel && htrans[1] && hready && (phase_ff == PH_IDLE);
  wire bus_wr   = (phase_ff == PH_ONE) && dp_write_ff;
  wire idle     = (st_ff == ST_IDLE);
  wire issue    = bus_wr && (dp_addr_ff == OFS_INSTR) && idle;
  wire wr_stat  = bus_wr && (dp_addr_ff == OFS_STATUS) && idle;
  wire wr_pc    = bus_wr && (dp_addr_ff == OFS_PC) && idle;
  wire wr_sel   = bus_wr && (dp_addr_ff == OFS_REG_SEL);
  wire wr_rdata = bus_wr && (dp_addr_ff == OFS_REG_DATA) && !wb_en_ff;

  // ==================== register bank
  wire [4:0]  rf_ra = (st_ff == ST_READ) ? src_f : reg_sel_ff;
  wire [4:0]  rf_rb = (is_ldq || is_ldr) ? base_r : dst_f;
  wire        rf_we = wb_en_ff || wr_rdata;
  wire [4:0]  rf_wa = wb_en_ff ? dst_f : reg_sel_ff;
  wire [31:0] rf_wd = wb_en_ff ? wb_data_ff : hwdata;

  reg_bank_2r1w #(.DW(DATA_W), .AW(RIDX_W)) u_bank (
    .clk        (hclk),
    .we         (rf_we),
    .waddr      (rf_wa),
    .wdata      (rf_wd),
    .raddr_a    (rf_ra),
    .raddr_b    (rf_rb),
    .rdata_a_ff (opa),
    .rdata_b_ff (opb)
  );

  // ==================== datapath
  // field zero stands for thirty-two
  wire [31:0] q_imm   = (src_f == 5'h00) ? QUICK_ZERO_VAL : {27'h0, src_f};
  wire        quick   = (op == OP_ADD_QUICK) || (op == OP_ADD_QUICK_FLAGLESS);
  wire [31:0] add_b   = quick ? q_imm : opa;
  wire        cin     = (op == OP_ADD_WITH_CARRY_IN) && c_ff;
  wire [32:0] sum     = {1'b0, opb} + {1'b0, add_b} + {32'h0, cin};
  wire [31:0] cmp_b   = (op == OP_COMPARE_QUICK) ? {{27{src_f[4]}}, src_f} : opa;
  wire [32:0] diff    = {1'b0, opb} - {1'b0, cmp_b};
  wire        is_min  = (opb == MIN_NEG);
  wire [31:0] neg_b   = 32'h0 - opb;
  wire [31:0] abs_res = (opb[31] && !is_min) ? neg_b : opb;
  wire [31:0] bmask   = 32'h1 << src_f;
  wire signed [31:0] prod = $signed(opa[15:0]) * $signed(opb[15:0]);
  wire [31:0] mac_sum = acc_ff + prod;
  wire sel_f  = dst_f[CC_FSEL] ? n_ff : c_ff;
  wire jmp_ok = !(dst_f[CC_ZCLR] && z_ff) && !(dst_f[CC_ZSET] && !z_ff)
             && !(dst_f[CC_FCLR] && sel_f) && !(dst_f[CC_FSET] && !sel_f);
  wire [31:0] pc_seq  = pc_ff + INSTR_BYTES;
  wire [31:0] rel_tgt = pc_seq + {{26{src_f[4]}}, src_f, 1'b0};
  wire [31:0] jmp_tgt = (op == OP_JABS) ? opa : rel_tgt;
  wire [31:0] ldq_adr = opb + {q_imm[29:0], 2'b00};
  wire [31:0] ldr_adr = opb + opa;
  wire [31:0] ld_adr  = is_ldq ? ldq_adr : (is_ldr ? ldr_adr : opa);
  wire [1:0]  ld_size = (op == OP_LDB) ? SZ_BYTE : ((op == OP_LDH) ? SZ_HALF : SZ_WORD);
  wire [31:0] ld_data = mem_internal ? mem_rdata
                      : (mem_size_ff == SZ_BYTE) ? {24'h0, mem_rdata[7:0]}
                      : (mem_size_ff == SZ_HALF) ? {16'h0, mem_rdata[15:0]} : mem_rdata;

  // ==================== divide step, two quotient bits
  function automatic logic [63:0] div2(input logic [31:0] r, input logic [31:0] q,
                                       input logic [31:0] d);
    logic [32:0] t;
    logic [31:0] rr, qq;
    rr = r;
    qq = q;
    for (int i = 0; i < 2; i++) begin
      t = {rr, qq[31]};
      qq = {qq[30:0], 1'b0};
      if (t >= {1'b0, d}) begin
        t = t - {1'b0, d};
        qq[0] = 1'b1;
      end
      rr = t[31:0];
    end
    return {rr, qq};
  endfunction
  wire [63:0] div_first = div2(32'h0, opb, opa);
  wire [63:0] div_next  = div2(rem_ff, quo_ff, dsr_ff);

  // ==================== alu result and flags
  logic [31:0] alu_res;
  logic        alu_wb, alu_z, alu_n, alu_c;
  always_comb begin
    alu_res = opb;
    alu_wb  = 1'b0;
    alu_z   = z_ff;
    alu_n   = n_ff;
    alu_c   = c_ff;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY_IN, OP_ADD_QUICK: begin
        alu_res = sum[31:0];
        alu_wb  = 1'b1;
        alu_z   = (sum[31:0] == 32'h0);
        alu_n   = sum[31];
        alu_c   = sum[32];
      end
      OP_ADD_QUICK_FLAGLESS: begin
        alu_res = sum[31:0];
        alu_wb  = 1'b1;
      end
      OP_AND: begin
        alu_res = opa & opb;
        alu_wb  = 1'b1;
        alu_z   = ((opa & opb) == 32'h0);
        alu_n   = opa[31] & opb[31];
      end
      OP_BIT_SET_OP, OP_BIT_CLEAR_OP: begin
        alu_res = (op == OP_BIT_SET_OP) ? (opb | bmask) : (opb & ~bmask);
        alu_wb  = 1'b1;
        alu_z   = (alu_res == 32'h0);
        alu_n   = alu_res[31];
      end
      OP_BPROBE: begin
        alu_z = !opb[src_f];
      end
      OP_MAG: begin
        alu_res = abs_res;
        alu_wb  = 1'b1;
        alu_z   = (abs_res == 32'h0);
        alu_n   = is_min;
        alu_c   = opb[31];
      end
      OP_CMP, OP_COMPARE_QUICK: begin
        alu_z = (diff[31:0] == 32'h0);
        alu_n = diff[31];
        alu_c = diff[32];
      end
      OP_IMUL, OP_IMULN: begin
        alu_res = prod;
        alu_wb  = (op == OP_IMUL);
        alu_z   = (prod == 32'h0);
        alu_n   = prod[31];
      end
      default: begin
        alu_res = opb;
      end
    endcase
  end

  // ==================== state sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (issue) nxt_st = ST_READ;
      ST_READ: nxt_st = ST_EXEC;
      ST_EXEC: begin
        if (op == OP_DIV) begin
          nxt_st = ST_DIV;
        end else if (is_ldq || is_ldr) begin
          nxt_st = ST_ADDR;
        end else if (is_ldd) begin
          nxt_st = ST_MEM;
        end else begin
          nxt_st = ST_WB;
        end
      end
      ST_DIV:  if (cnt_ff == DIV_ITER - 5'h01) nxt_st = ST_WB;
      ST_ADDR: nxt_st = ST_MEM;
      ST_MEM:  if (mem_ack) nxt_st = ST_WB;
      ST_WB:   nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  wire in_exec  = (st_ff == ST_EXEC);
  wire div_last = (st_ff == ST_DIV) && (cnt_ff == DIV_ITER - 5'h01);
  wire mem_done = (st_ff == ST_MEM) && mem_ack;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff    <= ST_IDLE;
      instr_ff <= 16'h0000;
      cnt_ff   <= 5'h00;
    end else begin
      st_ff <= nxt_st;
      if (issue) instr_ff <= hwdata[15:0];
      cnt_ff <= in_exec ? 5'h01 : cnt_ff + 5'h01;
    end
  end

  // ==================== write-back
  // write in cycle three, quotient in cycle eighteen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wb_en_ff   <= 1'b0;
      wb_data_ff <= 32'h0000_0000;
    end else begin
      wb_en_ff   <= (in_exec && alu_wb) || div_last || mem_done;
      wb_data_ff <= div_last ? div_next[31:0] : (mem_done ? ld_data : alu_res);
    end
  end

  // ==================== flags, pc, accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      z_ff    <= 1'b0;
      n_ff    <= 1'b0;
      c_ff    <= 1'b0;
      jump_ff <= 1'b0;
      pc_ff   <= PC_RESET;
    end else if (in_exec) begin
      {z_ff, n_ff, c_ff} <= {alu_z, alu_n, alu_c};
      jump_ff <= is_jmp && jmp_ok;
      pc_ff   <= (is_jmp && jmp_ok) ? jmp_tgt : pc_seq;
    end else begin
      if (wr_stat) {z_ff, n_ff, c_ff} <= {hwdata[STB_ZERO], hwdata[STB_NEG], hwdata[STB_CARRY]};
      if (wr_pc) pc_ff <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 32'h0000_0000;
    end else if (in_exec && (op == OP_IMULN || op == OP_IMUL)) begin
      acc_ff <= prod;
    end else if (in_exec && op == OP_IMACN) begin
      acc_ff <= mac_sum;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_ff <= 32'h0000_0000;
      quo_ff <= 32'h0000_0000;
      dsr_ff <= 32'h0000_0000;
    end else if (in_exec && op == OP_DIV) begin
      {rem_ff, quo_ff} <= div_first;
      dsr_ff <= opa;
    end else if (st_ff == ST_DIV) begin
      {rem_ff, quo_ff} <= div_next;
    end
  end

  // ==================== memory request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_ff  <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
      mem_size_ff <= SZ_WORD;
    end else begin
      if (in_exec && (is_ldd || is_ldq || is_ldr)) begin
        mem_addr_ff <= ld_adr;
        mem_size_ff <= ld_size;
      end
      mem_req_ff <= (nxt_st == ST_MEM) && !mem_done;
    end
  end

  // ==================== ahb-lite slave
  wire [31:0] status_w = {27'h0, jump_ff, c_ff, n_ff, z_ff, !idle};
  wire [31:0] rd_mux = (dp_addr_ff == OFS_INSTR)    ? {16'h0, instr_ff}
                     : (dp_addr_ff == OFS_STATUS)   ? status_w
                     : (dp_addr_ff == OFS_PC)       ? pc_ff
                     : (dp_addr_ff == OFS_REMAIN)   ? rem_ff
                     : (dp_addr_ff == OFS_ACC)      ? acc_ff
                     : (dp_addr_ff == OFS_REG_SEL)  ? {27'h0, reg_sel_ff}
                     : (dp_addr_ff == OFS_REG_DATA) ? opa : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff     <= PH_IDLE;
      dp_addr_ff   <= 8'h00;
      dp_write_ff  <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h0000_0000;
      hresp_ff     <= 1'b0;
      reg_sel_ff   <= 5'h00;
    end else begin
      hresp_ff <= 1'b0;
      if (accept) begin
        phase_ff     <= PH_ONE;
        dp_addr_ff   <= haddr;
        dp_write_ff  <= hwrite;
        hreadyout_ff <= 1'b0;
      end else if (phase_ff == PH_ONE) begin
        phase_ff <= PH_TWO;
      end else if (phase_ff == PH_TWO) begin
        phase_ff     <= PH_IDLE;
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= dp_write_ff ? 32'h0000_0000 : rd_mux;
      end
      if (wr_sel) reg_sel_ff <= hwdata[4:0];
    end
  end

  // ==================== assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence bus_wait_s;
    !hreadyout_ff ##1 !hreadyout_ff ##1 hreadyout_ff;
  endsequence
  sequence exec_of_s(logic [5:0] o);
    in_exec && (op == o);
  endsequence

  AST_BUS_WAIT: assert property (accept |=> bus_wait_s)
    else $error("bus data phase length wrong");
  AST_ADD_WB: assert property (st_ff == ST_READ && op == OP_ADD |-> ##2
      (wb_en_ff && wb_data_ff == $past(opa, 1) + $past(opb, 1)))
    else $error("add result not written in cycle three");
  AST_ADD_QUICK_FLAGLESS_FLAGS: assert property (exec_of_s(OP_ADD_QUICK_FLAGLESS) |=> $stable({z_ff, n_ff, c_ff}))
    else $error("flagless quick add changed flags");
  AST_MAG_FLAGS: assert property (exec_of_s(OP_MAG) |=>
      (c_ff == $past(opb[31]) && n_ff == ($past(opb) == MIN_NEG)))
    else $error("magnitude flags wrong");
  AST_CMP_NOSTORE: assert property (exec_of_s(OP_CMP) |=>
      (!wb_en_ff && z_ff == ($past(opa) == $past(opb))))
    else $error("compare stored or zero flag wrong");
  AST_DIV_CYCLE: assert property (st_ff == ST_READ && op == OP_DIV |->
      ##17 (wb_en_ff && $stable({z_ff, n_ff, c_ff})))
    else $error("quotient not written in cycle eighteen");
  AST_MAC_ACC: assert property (exec_of_s(OP_IMACN) |=>
      (!wb_en_ff && acc_ff == $past(mac_sum) && $stable({z_ff, n_ff, c_ff})))
    else $error("accumulate wrong");
  AST_JUMP_PC: assert property (in_exec && is_jmp |=>
      ($stable({z_ff, n_ff, c_ff}) && pc_ff == ($past(jmp_ok) ? $past(jmp_tgt) : $past(pc_seq))))
    else $error("jump target or flags wrong");
  AST_LD_ADDR: assert property (exec_of_s(OP_LD) |=>
      (mem_req_ff && mem_addr_ff == $past(opa) && mem_size_ff == SZ_WORD))
    else $error("load request wrong");
endmodule // risc_alu_branch_load_exec
`default_nettype wire

// ### tb/mem_partner.sv
// memory bus partner answering loads after a set latency
`timescale 1ns/1ns
`default_nettype none
module mem_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // memory bus
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  lat,
  input  wire logic        intl,
  output var  logic        ack,
  output var  logic        internal,
  output var  logic [31:0] rdata
);
  logic [3:0] cnt_ff;
  // ==================== answer after lat waiting cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      ack <= 1'b0;
      rdata <= 32'h0;
    end else if (!ack && req && cnt_ff == lat) begin
      ack <= 1'b1;
      rdata <= addr ^ 32'h5A5A_0F0F;
    end else begin
      ack <= 1'b0;
      cnt_ff <= (req && !ack) ? cnt_ff + 4'h1 : 4'h0;
      rdata <= ~rdata;
    end
  end
  assign internal = ack ? intl : ~intl;
endmodule // mem_partner
`default_nettype wire

// ### tb/risc_alu_branch_load_exec_tb.sv
// self-checking bench for the execute block
`timescale 1ns/1ns
`default_nettype none
module risc_alu_branch_load_exec_tb;
  import risc_exec_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, intl = 1'b0;
  logic        hreadyout_ff, hresp_ff, mem_req_ff, mem_ack, mem_internal;
  logic [1:0]  htrans = 2'h0, mem_size_ff;
  logic [7:0]  haddr = 8'h00;
  logic [3:0]  lat = 4'h0;
  logic [2:0]  fl;
  logic [31:0] hwdata = 32'h0, hrdata_ff, mem_addr_ff, mem_rdata, rd, acc;
  logic [5:0]  al_ops [13] = '{OP_ADD, OP_ADD_WITH_CARRY_IN, OP_ADD_QUICK, OP_ADD_QUICK_FLAGLESS, OP_AND, OP_BPROBE,
                               OP_BIT_SET_OP, OP_BIT_CLEAR_OP, OP_IMUL, OP_DIV, OP_MAG, OP_CMP, OP_COMPARE_QUICK};
  logic [5:0]  ld_ops [7] = '{OP_LD, OP_LDB, OP_LDH, OP_LDQA, OP_LDQB, OP_LDRA, OP_LDRB};
  int          fail_count = 0, checks_done = 0, seed = 60191;
  always #25 hclk = ~hclk;
  risc_alu_branch_load_exec risc_alu_branch_load_exec_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff), .mem_size_ff(mem_size_ff),
    .mem_ack(mem_ack), .mem_internal(mem_internal), .mem_rdata(mem_rdata));
  mem_partner mem_partner_inst (.clk(hclk), .rst_n(hresetn), .req(mem_req_ff),
    .addr(mem_addr_ff), .lat(lat), .intl(intl), .ack(mem_ack), .internal(mem_internal),
    .rdata(mem_rdata));
  // ==================== reporting
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ==================== bus master
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout_ff !== 1'b1 && n < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout_ff !== 1'b1 && n < 99);
    rd = hrdata_ff;
    chk({31'h0, hresp_ff}, 32'h0);
    if (n >= 99) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  task automatic setr(input logic [4:0] r, input logic [31:0] v);
    bus(1'b1, OFS_REG_SEL, {27'h0, r});
    bus(1'b1, OFS_REG_DATA, v);
  endtask
  task automatic getr(input logic [4:0] r);
    bus(1'b1, OFS_REG_SEL, {27'h0, r});
    bus(1'b0, OFS_REG_DATA, 32'h0);
  endtask
  task automatic run(input logic [5:0] op, input logic [4:0] f, input logic [4:0] g);
    int n;
    n = 0;
    bus(1'b1, OFS_INSTR, {16'h0, op, f, g});
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STB_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  // ==================== expectations, flags as {c,n,z}
  function automatic logic [34:0] model(input logic [5:0] op, input logic [31:0] s,
                                         input logic [31:0] d, input logic [4:0] f);
    logic [32:0] t;
    logic [31:0] q;
    logic [2:0]  o;
    o = fl;
    q = d;
    t = {1'b0, d} + {1'b0, op[1] ? {24'h0, f == 5'h0, f, 2'h0} >> 2 : s}
        + {32'h0, op == OP_ADD_WITH_CARRY_IN && fl[2]};
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY_IN, OP_ADD_QUICK: {o[2], q} = t;
      OP_ADD_QUICK_FLAGLESS: q = t[31:0];
      OP_AND: q = s & d;
      OP_BIT_SET_OP: q = d | (32'h1 << f);
      OP_BIT_CLEAR_OP: q = d & ~(32'h1 << f);
      OP_IMUL: q = $signed(s[15:0]) * $signed(d[15:0]);
      OP_IMULN: q = $signed(s[15:0]) * $signed(d[15:0]);
      OP_MAG: {o[2], q} = {d[31], d[31] ? -d : d};
      OP_DIV: q = s == 32'h0 ? 32'hFFFF_FFFF : d / s;
      OP_CMP, OP_COMPARE_QUICK: begin
        t = {1'b0, d} - {1'b0, op[0] ? {{27{f[4]}}, f} : s};
        {o[2], q} = t;
      end
      default: ;
    endcase
    if (op == OP_BPROBE) o[0] = ~d[f];
    else if (!(op inside {OP_ADD_QUICK_FLAGLESS, OP_DIV, OP_IMACN})) o[1:0] = {q[31], q == 32'h0};
    if (op inside {OP_CMP, OP_COMPARE_QUICK, OP_BPROBE, OP_IMULN, OP_IMACN}) q = d;
    return {o, q};
  endfunction
  function automatic logic jt(input logic [4:0] c, input logic [2:0] k);
    logic x;
    x = c[4] ? k[1] : k[2];
    return !(c[0] && k[0]) && !(c[1] && !k[0]) && !(c[2] && x) && !(c[3] && !x);
  endfunction
  // ==================== scenarios
  task automatic sweep(input logic [5:0] op, input int k);
    logic [34:0] e;
    logic [31:0] s, d, p;
    logic [4:0]  f;
    for (int i = 0; i < k; i++) begin
      s = $random(seed);
      d = i == 0 ? MIN_NEG : i == 1 ? 32'hFFFF_FFFF : $random(seed);
      f = i == 0 ? 5'h0 : i == 1 ? 5'h1F : 5'($random(seed));
      fl = 3'($random(seed));
      setr(f, s);
      setr(f ^ 5'h10, d);
      bus(1'b1, OFS_STATUS, {28'h0, fl, 1'b0});
      e = model(op, s, d, f);
      run(op, f, f ^ 5'h10);
      chk({29'h0, rd[3:1]}, {29'h0, e[34:32]});
      getr(f ^ 5'h10);
      chk(rd, e[31:0]);
      if (op == OP_DIV && s != 32'h0) begin
        bus(1'b0, OFS_REMAIN, 32'h0);
        chk(rd, d % s);
      end
      if (op == OP_IMULN || op == OP_IMACN) begin
        p = $signed(s[15:0]) * $signed(d[15:0]);
        acc = p + (op == OP_IMACN ? acc : 32'h0);
        bus(1'b0, OFS_ACC, 32'h0);
        chk(rd, acc);
      end
    end
  endtask
  task automatic jumps;
    logic [31:0] p, s, e;
    logic [4:0]  f;
    logic        tk;
    for (int i = 0; i < 64; i++) begin
      p = 32'($random(seed)) & 32'h0000_FFFE;
      s = 32'($random(seed)) & 32'h0000_FFFE;
      f = 5'($random(seed));
      fl = 3'($random(seed));
      setr(f, s);
      bus(1'b1, OFS_PC, p);
      bus(1'b1, OFS_STATUS, {28'h0, fl, 1'b0});
      tk = jt(5'(i), fl);
      e = !tk ? p + 2 : i[5] ? p + 2 + {{26{f[4]}}, f, 1'b0} : s;
      run(i[5] ? OP_JREL : OP_JABS, f, 5'(i));
      chk({28'h0, rd[4:1]}, {28'h0, tk, fl});
      bus(1'b0, OFS_PC, 32'h0);
      chk(rd, e);
    end
  endtask
  task automatic loads;
    logic [5:0]  op;
    logic [31:0] a, b, v;
    logic [4:0]  f;
    for (int i = 0; i < 42; i++) begin
      op = ld_ops[i % 7];
      f = 5'(i / 7);
      a = 32'($random(seed)) & 32'hFFFF_FFFC;
      b = 32'($random(seed)) & 32'hFFFF_FFFC;
      lat <= 4'($random(seed));
      intl <= 1'($random(seed));
      setr(f, a);
      setr(IDX_BASE_A, b);
      setr(IDX_BASE_B, b + 32'h100);
      if (op == OP_LDQB || op == OP_LDRB) b = b + 32'h100;
      v = op inside {OP_LDQA, OP_LDQB} ? {24'h0, f == 5'h0, f, 2'h0} + b
        : op inside {OP_LDRA, OP_LDRB} ? a + b : a;
      v = v ^ 32'h5A5A_0F0F;
      if (!intl && op == OP_LDB) v = v & 32'h0000_00FF;
      if (!intl && op == OP_LDH) v = v & 32'h0000_FFFF;
      run(op, f, f + 5'h10);
      getr(f + 5'h10);
      chk(rd, v);
    end
  endtask
  // ==================== main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    foreach (al_ops[j]) sweep(al_ops[j], 6);
    jumps;
    loads;
    sweep(OP_IMULN, 3);
    sweep(OP_IMACN, 4);
    report_and_stop;
  end
endmodule // risc_alu_branch_load_exec_tb
`default_nettype wire
